// ==== core/uevs_pkg.sv ====
/*
  Package for the USB event status flag slice: register offsets, bit
  positions, reset values and timing constants.
  Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package uevs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] UEVS_ADDR_STATUS = 4'h0;
  localparam logic [3:0] UEVS_ADDR_MASK = 4'h4;
  localparam logic [3:0] UEVS_ADDR_DCTL = 4'h8;
  localparam logic [3:0] UEVS_ADDR_CFG = 4'hC;

  // ==========================================================
  // Status and mask bit positions
  localparam int UEVS_B_ENUM = 13;
  localparam int UEVS_B_BRST = 12;
  localparam int UEVS_B_SUSP = 11;
  localparam int UEVS_B_EARLY = 10;
  localparam int UEVS_B_ONAK = 7;
  localparam int UEVS_B_INAK = 6;
  localparam int UEVS_B_NPTX = 5;
  localparam int UEVS_B_RXP = 4;
  localparam int UEVS_STAT_W = 14;

  // Write-one-to-clear bits, writable mask bits and mask reset value
  localparam logic [13:0] UEVS_W1C_BITS = 14'h3C00;
  localparam logic [13:0] UEVS_MASK_BITS = 14'h3CF0;
  localparam logic [13:0] UEVS_MASK_RST = 14'h0000;

  // ==========================================================
  // Device control register bits
  localparam int UEVS_D_SET_ONAK = 0;
  localparam int UEVS_D_CLR_ONAK = 1;
  localparam int UEVS_D_SET_INAK = 2;
  localparam int UEVS_D_CLR_INAK = 3;

  // Configuration register bits
  localparam int UEVS_C_HOST = 0;
  localparam int UEVS_C_EMPTY_LVL = 1;

  // ==========================================================
  // Transmit FIFO geometry
  localparam int UEVS_TXF_AW = 9;
  localparam logic [8:0] UEVS_TXF_DEPTH = 9'h100;
  localparam logic [8:0] UEVS_TXF_HALF = 9'h080;

  // ==========================================================
  // Timing
  localparam int UEVS_CLK_MHZ = 125;
  localparam int UEVS_EARLY_US = 3000;
  localparam int UEVS_EARLY_CYC = UEVS_EARLY_US * UEVS_CLK_MHZ;
  localparam int UEVS_SUSP_US = 3000;
  localparam int UEVS_SUSP_CYC = UEVS_SUSP_US * UEVS_CLK_MHZ;
  localparam int UEVS_CNT_W = 20;

endpackage : uevs_pkg

// ==== core/uevs_idle_if.sv ====
/*
  Interface between the event status top and its bus idle timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface uevs_idle_if;
  logic enable;
  logic bus_idle;
  logic early_pulse;
  logic susp_pulse;

  modport timer
  (
    input enable,
    input bus_idle,
    output early_pulse,
    output susp_pulse
  );
  modport user
  (
    output enable,
    output bus_idle,
    input early_pulse,
    input susp_pulse
  );
endinterface : uevs_idle_if

// ==== core/uevs_idle_timer.sv ====
/*
  Bus idle timer: pulses once when the bus has been idle for the early
  threshold and once at the suspend threshold.
  Assumes bus_idle is synchronous to clk; enable low holds it cleared.
*/
`timescale 1ns/1ps
module uevs_idle_timer
  import uevs_pkg::*;
#(
  parameter int EARLY_CYC = UEVS_EARLY_CYC,
  parameter int SUSP_CYC = UEVS_SUSP_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  uevs_idle_if.timer idl
);

  typedef struct packed {
    logic [UEVS_CNT_W-1:0] cnt;
    logic early;
    logic susp;
  } uevs_tmr_t;

  uevs_tmr_t st_r;
  uevs_tmr_t st_nxt;

  localparam logic [UEVS_CNT_W-1:0] EARLY_LAST =
    UEVS_CNT_W'(EARLY_CYC - 1);
  localparam logic [UEVS_CNT_W-1:0] SUSP_LAST =
    UEVS_CNT_W'(SUSP_CYC - 1);
  // Count stops at the suspend count; early must not exceed it
  localparam logic [UEVS_CNT_W-1:0] SUSP_STOP =
    UEVS_CNT_W'(SUSP_CYC);

  // ==========================================================
  // Counter
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.early = 1'b0;
    st_nxt.susp = 1'b0;
    if (!idl.enable || !idl.bus_idle)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt != SUSP_STOP)
    begin
      // Saturates so each threshold fires once per idle stretch
      st_nxt.cnt = st_r.cnt + 1'b1;
      st_nxt.early = (st_r.cnt == EARLY_LAST);
      st_nxt.susp = (st_r.cnt == SUSP_LAST);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign idl.early_pulse = st_r.early;
  assign idl.susp_pulse = st_r.susp;

endmodule : uevs_idle_timer

// ==== core/uevs_top.sv ====
/*
  USB event status flag slice (status bits 13..4) with mask, device
  control strobes, configuration and one level interrupt, on Avalon-MM.
  Assumes all inputs are synchronous to clk and the USB line logic
  reports reset, enumeration done, bus idle and FIFO levels.
*/
// Overview of operation
// - Device mode sets enumeration-done flag bit 13; write one clears
// - Device mode sets bus-reset flag bit 12 on line reset; W1C
// - Device mode sets suspend flag bit 11 after long idle; W1C
// - Device mode sets early-suspend bit 10 after 3 ms idle; W1C
// - Bits 9 and 8 read zero; software leaves them default
// - OUT-NAK-effective bit 7 rises once global OUT NAK takes effect
// - Bit 7 clears via clear-OUT-NAK control or host mode, not status write
// - IN-NAK-effective bit 6 rises once global IN NAK is sampled
// - Bit 6 clears via clear-IN-NAK control write
// - IN NAK effect does not imply NAK sent; STALL wins
// - Bit 5 resets one; set when FIFO at threshold and queue space
// - Threshold is half or fully empty, per empty-level config bit
// - Bit 4 set while receive FIFO holds a packet
// - Cleared mask bit blocks interrupt but flag still sets
`timescale 1ns/1ps
module uevs_top
  import uevs_pkg::*;
#(
  parameter int EARLY_CYC = UEVS_EARLY_CYC,
  parameter int SUSP_CYC = UEVS_SUSP_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic line_reset,
  input wire logic enum_done,
  input wire logic bus_idle,
  input wire logic out_path_idle,
  input wire logic in_token_seen,
  input wire logic ep_stalled,
  input wire logic [8:0] txf_free_words,
  input wire logic txq_has_space,
  input wire logic [7:0] rx_packet_count,
  output logic irq,
  output logic host_mode,
  output logic out_nak_active,
  output logic in_nak_reply,
  output logic in_stall_reply
);

  typedef struct packed {
    logic [13:0] stat;
    logic [13:0] mask;
    logic host;
    logic empty_lvl;
    logic onak_req;
    logic inak_req;
    logic ack;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic in_nak;
    logic in_stall;
  } uevs_state_t;

  uevs_state_t st_r;
  uevs_state_t st_nxt;
  uevs_idle_if idl ();

  logic wr_go;
  logic rd_go;
  logic [13:0] wdat;
  logic [13:0] set_ev;
  logic tx_ok;

  // ==========================================================
  // Bus idle timer
  assign idl.enable = !st_r.host;
  assign idl.bus_idle = bus_idle;

  uevs_idle_timer #(
    .EARLY_CYC(EARLY_CYC),
    .SUSP_CYC(SUSP_CYC)
  ) u_idle (
    .clk(clk),
    .srst(srst),
    .idl(idl)
  );

  // ==========================================================
  // Bus access: one wait cycle, answer on the second edge
  // Writes commit at the edge that ends the wait, as the master sees it
  assign wr_go = avs_write && st_r.ack;
  assign rd_go = avs_read && !st_r.ack;
  // Low two lanes carry all implemented bits
  assign wdat = {avs_byteenable[1] ? avs_writedata[13:8] : 6'h00,
                 avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  // ==========================================================
  // Event sources
  always_comb
  begin
    set_ev = '0;
    set_ev[UEVS_B_ENUM] = enum_done;
    set_ev[UEVS_B_BRST] = line_reset;
    set_ev[UEVS_B_SUSP] = idl.susp_pulse;
    set_ev[UEVS_B_EARLY] = idl.early_pulse;
  end

  assign tx_ok = st_r.empty_lvl ? (txf_free_words == UEVS_TXF_DEPTH)
                                : (txf_free_words >= UEVS_TXF_HALF);

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    // Single-cycle waitrequest low per access
    if ((avs_read || avs_write) && !st_r.ack)
    begin
      st_nxt.ack = 1'b1;
    end
    st_nxt.wreq = !st_nxt.ack;

    // Write one to clear on W1C bits only; set wins over clear
    if (wr_go && avs_address == UEVS_ADDR_STATUS)
    begin
      st_nxt.stat = st_r.stat & ~(wdat & UEVS_W1C_BITS);
    end
    st_nxt.stat = st_nxt.stat | set_ev;

    if (wr_go && avs_address == UEVS_ADDR_MASK)
    begin
      st_nxt.mask = wdat & UEVS_MASK_BITS;
    end
    if (wr_go && avs_address == UEVS_ADDR_CFG && avs_byteenable[0])
    begin
      st_nxt.host = avs_writedata[UEVS_C_HOST];
      st_nxt.empty_lvl = avs_writedata[UEVS_C_EMPTY_LVL];
    end

    // Effect first, so a clear control in this cycle still wins
    // OUT NAK takes effect once no OUT packet is in flight
    if (st_r.onak_req && out_path_idle)
    begin
      st_nxt.stat[UEVS_B_ONAK] = 1'b1;
    end
    // IN NAK takes effect as soon as the request is sampled
    if (st_r.inak_req)
    begin
      st_nxt.stat[UEVS_B_INAK] = 1'b1;
    end

    // Global NAK requests; clear wins if both written together
    if (wr_go && avs_address == UEVS_ADDR_DCTL && avs_byteenable[0])
    begin
      if (avs_writedata[UEVS_D_SET_ONAK])
      begin
        st_nxt.onak_req = 1'b1;
      end
      if (avs_writedata[UEVS_D_SET_INAK])
      begin
        st_nxt.inak_req = 1'b1;
      end
      if (avs_writedata[UEVS_D_CLR_ONAK])
      begin
        st_nxt.onak_req = 1'b0;
        st_nxt.stat[UEVS_B_ONAK] = 1'b0;
      end
      if (avs_writedata[UEVS_D_CLR_INAK])
      begin
        st_nxt.inak_req = 1'b0;
        st_nxt.stat[UEVS_B_INAK] = 1'b0;
      end
    end

    // IN token reply: STALL has priority over NAK
    st_nxt.in_stall = in_token_seen && ep_stalled;
    st_nxt.in_nak = in_token_seen && !ep_stalled
                    && st_r.stat[UEVS_B_INAK];

    st_nxt.stat[UEVS_B_NPTX] = tx_ok && txq_has_space;
    st_nxt.stat[UEVS_B_RXP] = (rx_packet_count != 8'h00);
    st_nxt.stat[9:8] = 2'b00;

    // Device-only flags and requests forced idle in host mode
    if (st_r.host)
    begin
      st_nxt.stat[13:6] = 8'h00;
      st_nxt.onak_req = 1'b0;
      st_nxt.inak_req = 1'b0;
      st_nxt.in_nak = 1'b0;
    end

    st_nxt.irq = |(st_r.stat & st_r.mask);

    st_nxt.rdata = '0;
    if (rd_go)
    begin
      unique case (avs_address)
        UEVS_ADDR_STATUS: st_nxt.rdata = {18'h00000, st_r.stat};
        UEVS_ADDR_MASK: st_nxt.rdata = {18'h00000, st_r.mask};
        UEVS_ADDR_DCTL: st_nxt.rdata = {30'h00000000, st_r.inak_req,
                                        st_r.onak_req};
        UEVS_ADDR_CFG: st_nxt.rdata = {30'h00000000, st_r.empty_lvl,
                                       st_r.host};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.mask <= UEVS_MASK_RST;
      st_r.wreq <= 1'b1;
      st_r.stat[UEVS_B_NPTX] <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wreq;
  assign irq = st_r.irq;
  assign host_mode = st_r.host;
  assign out_nak_active = st_r.stat[UEVS_B_ONAK];
  assign in_nak_reply = st_r.in_nak;
  assign in_stall_reply = st_r.in_stall;

endmodule : uevs_top

// ==== verif/uevs_chk.sv ====
/*
  Port checker for the event status slice.
  Assumes a bind to uevs_top; it sees that module's ports only.
*/
`timescale 1ns/1ps
module uevs_chk
  import uevs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic in_token_seen,
  input wire logic ep_stalled,
  input wire logic host_mode,
  input wire logic out_nak_active,
  input wire logic in_nak_reply,
  input wire logic in_stall_reply
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic st_rd;
  assign st_rd = avs_read && !avs_waitrequest && avs_address == 4'h0;
  wait_one_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");
  wait_single_a: assert property
    (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  rdata_idle_a: assert property
    (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer");
  resv_zero_a: assert property
    (st_rd |-> avs_readdata[31:14] == 18'h0 && avs_readdata[9:8] == 2'h0)
    else $error("reserved bits set");
  host_clear_a: assert property
    (st_rd && host_mode && $past(host_mode, 2)
      |-> avs_readdata[13:6] == 8'h0)
    else $error("device flags in host mode");
  stall_wins_a: assert property
    (in_token_seen && ep_stalled |=> in_stall_reply && !in_nak_reply)
    else $error("stall lost to nak");
  reply_cause_a: assert property
    (!in_token_seen |=> !in_nak_reply && !in_stall_reply)
    else $error("reply without token");
  onak_hold_a: assert property
    (out_nak_active && !avs_write && !$past(avs_write)
      && !$past(avs_write, 2) |=> out_nak_active)
    else $error("out nak dropped alone");
endmodule : uevs_chk

bind uevs_top uevs_chk u_uevs_chk (.*);

// ==== verif/uevs_usb_model.sv ====
/*
  Far side model: USB line events and endpoint stall state.
  Assumes send is called just after a rising clock edge.
*/
`timescale 1ns/1ps
module uevs_usb_model
(
  input wire logic clk,
  output logic enum_done,
  output logic line_reset,
  output logic bus_idle,
  output logic in_token_seen,
  output logic ep_stalled
);
  // ==========================================================
  // Line events; every line returns low, none floats
  logic [4:0] ln = 5'h0;
  assign {ep_stalled, in_token_seen, bus_idle, line_reset, enum_done} = ln;
  task automatic send(input logic [4:0] sel, input int n);
    ln <= sel;
    repeat (n) @(posedge clk);
    ln <= 5'h0;
  endtask : send
endmodule : uevs_usb_model

// ==== verif/uevs_top_test.sv ====
/*
  Self-checking bench for uevs_top with the far side model.
  Assumes the checker is bound in its own file.
*/
`timescale 1ns/1ps
module uevs_top_test
  import uevs_pkg::*;
;
  localparam logic [3:0] S = UEVS_ADDR_STATUS;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, irq, host_mode;
  logic out_path_idle, txq_has_space, out_nak_active, in_nak_reply;
  logic in_stall_reply, line_reset, enum_done, bus_idle, in_token_seen;
  logic ep_stalled;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [8:0] txf_free_words;
  logic [7:0] rx_packet_count;
  logic [8:0] fw [4] = '{9'h07F, 9'h080, 9'h0FF, 9'h100};
  int err_count, check_count, tn, i, seed;
  // Short idle counts keep the run brief
  uevs_top #(.EARLY_CYC(20), .SUSP_CYC(40)) u_uevs_top (.*);
  uevs_usb_model u_uevs_usb_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] st_exp(input logic [8:0] f,
    input logic s, input logic e, input logic [7:0] r);
    logic hit;
    hit = e ? f == UEVS_TXF_DEPTH : f >= UEVS_TXF_HALF;
    return {26'h0, hit & s, r != 8'h0, 4'h0};
  endfunction : st_exp
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] dd);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= dd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (n >= 64)
    begin
      err_count++;
      print_verdict();
    end
  endtask : bus
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  task automatic co(input logic [2:0] e);
    @(negedge clk);
    chk({irq, in_stall_reply, in_nak_reply}, e);
    @(posedge clk);
  endtask : co
  task automatic tend();
    tn++;
    $display("test %0d done", tn);
  endtask : tend
  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h9860B868;
    srst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {out_path_idle, rx_packet_count} = '0;
    avs_byteenable = 4'hF;
    txf_free_words = 9'h100;
    txq_has_space = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc(S, 32'h20);
    rc(4'h2, 32'h0);
    d = $random(seed);
    bus(1'b1, UEVS_ADDR_MASK, d);
    rc(UEVS_ADDR_MASK, d & 32'(UEVS_MASK_BITS));
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, UEVS_ADDR_MASK, 32'h0);
      u_uevs_usb_model.send(5'h1 << i, 1);
      d = 32'h2000 >> i;
      rc(S, 32'h20 | d);
      co(3'h0);
      bus(1'b1, UEVS_ADDR_MASK, d);
      co(3'h4);
      bus(1'b1, S, 32'h0);
      rc(S, 32'h20 | d);
      bus(1'b1, S, d);
      rc(S, 32'h20);
    end
    u_uevs_usb_model.send(5'h4, 15);
    rc(S, 32'h20);
    u_uevs_usb_model.send(5'h4, 45);
    rc(S, 32'hC20);
    bus(1'b1, S, 32'hC00);
    tend();
    bus(1'b1, UEVS_ADDR_DCTL, 32'h1);
    rc(S, 32'h20);
    out_path_idle <= 1'b1;
    repeat (4) @(posedge clk);
    rc(S, 32'hA0);
    chk({31'h0, out_nak_active}, 32'h1);
    bus(1'b1, S, 32'hFFFF);
    rc(S, 32'hA0);
    bus(1'b1, UEVS_ADDR_DCTL, 32'h2);
    rc(S, 32'h20);
    chk({31'h0, out_nak_active}, 32'h0);
    bus(1'b1, UEVS_ADDR_DCTL, 32'h4);
    rc(S, 32'h60);
    u_uevs_usb_model.send(5'h8, 1);
    co(3'h1);
    u_uevs_usb_model.send(5'h18, 1);
    co(3'h2);
    bus(1'b1, UEVS_ADDR_DCTL, 32'h8);
    rc(S, 32'h20);
    tend();
    for (i = 0; i < 8; i++)
    begin
      txf_free_words <= fw[i / 2];
      txq_has_space <= (i % 3 != 2);
      rx_packet_count <= (i == 0) ? 8'h0 : 8'($random(seed));
      bus(1'b1, UEVS_ADDR_CFG, 32'(i % 2) << 1);
      d = st_exp(txf_free_words, txq_has_space, 1'(i % 2), rx_packet_count);
      rc(S, d);
    end
    tend();
    txf_free_words <= 9'h100;
    txq_has_space <= 1'b1;
    rx_packet_count <= 8'h0;
    bus(1'b1, UEVS_ADDR_CFG, 32'h1);
    chk({31'h0, host_mode}, 32'h1);
    u_uevs_usb_model.send(5'h3, 2);
    bus(1'b1, UEVS_ADDR_DCTL, 32'h5);
    rc(S, 32'h20);
    tend();
    print_verdict();
  end
endmodule : uevs_top_test
